// ---- include/brake_link_if.sv ----
// Carrier between the routing top and the holding brake sequencer
`timescale 1ns/1ps
`default_nettype none
interface brake_link_if;
	import io_route_pkg::*;
	logic servo_on_req;
	logic below_speed;
	logic [BRAKE_PARAM_W-1:0] wait_stop;
	logic [BRAKE_PARAM_W-1:0] wait_run;
	logic brake_release;
	logic servo_energized;

	modport ctl (
		output servo_on_req,
		output below_speed,
		output wait_stop,
		output wait_run,
		input brake_release,
		input servo_energized
	);

	modport tmr (
		input servo_on_req,
		input below_speed,
		input wait_stop,
		input wait_run,
		output brake_release,
		output servo_energized
	);
endinterface
`default_nettype wire

// ---- include/io_route_pkg.sv ----
// Shared constants, codes and types for the control connector I/O routing
package io_route_pkg;
	// Clock rate and brake timing unit
	localparam int CLK_PERIOD_NS = 50;
	localparam int BRAKE_TICK_US = 10000;
	localparam int BRAKE_TICK_CYCLES = (BRAKE_TICK_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int BRAKE_PARAM_W = 8;

	// Input terminal selection codes
	localparam int N_IN_TERMS = 7;
	localparam int SEL_W = 4;
	localparam logic [SEL_W-1:0] LATCH_TERM_FIRST = 4'h4;
	localparam logic [SEL_W-1:0] LATCH_TERM_LAST = 4'h6;

	// Field positions inside the third input allocation word
	localparam int DECEL_LSB = 0;
	localparam int LATCH_A_LSB = 4;
	localparam int LATCH_B_LSB = 8;
	localparam int LATCH_C_LSB = 12;

	// Field positions inside the output allocation words
	localparam int PAIR1_LSB = 0;
	localparam int PAIR2_LSB = 4;
	localparam int PAIR3_LSB = 0;

	typedef enum logic [3:0] {
		FUNC_NONE = 4'h0,
		FUNC_POS_DONE_A = 4'h1,
		FUNC_POS_DONE_B = 4'h2,
		FUNC_SPEED_MATCH = 4'h3,
		FUNC_ROTATION = 4'h4,
		FUNC_READY = 4'h5,
		FUNC_CUR_CLAMP = 4'h6,
		FUNC_SPD_CLAMP = 4'h7,
		FUNC_BRAKE = 4'h8,
		FUNC_WARN = 4'h9
	} out_func_t;

	typedef enum logic [1:0] {
		MODE_POSITION = 2'h0,
		MODE_SPEED = 2'h1,
		MODE_TORQUE = 2'h2
	} ctrl_mode_t;

	typedef enum logic [1:0] {
		BRK_OFF = 2'h0,
		BRK_ON_RUN = 2'h1,
		BRK_STOP_HOLD = 2'h2,
		BRK_RUN_COAST = 2'h3
	} brake_state_t;

	localparam logic LVL_OFF = 1'b0;
endpackage

// ---- logic/brake_sequencer.sv ----
// Holding brake sequencer with stop-hold and run-coast waits
`timescale 1ns/1ps
`default_nettype none
module brake_sequencer
	import io_route_pkg::*;
#(
	parameter int TICK_CYCLES = BRAKE_TICK_CYCLES
)
(
	input wire logic ref_clk,
	input wire logic sys_rst,
	brake_link_if.tmr lnk
);
	localparam int CNT_W = $clog2(TICK_CYCLES + 1);
	localparam logic [CNT_W-1:0] TICK_LAST = CNT_W'(TICK_CYCLES - 1);

	brake_state_t st_r;
	brake_state_t st_nxt;
	logic [CNT_W-1:0] cnt_r;
	logic [BRAKE_PARAM_W-1:0] ticks_r;
	logic release_r;
	logic energized_r;
	wire logic waiting = (st_r == BRK_STOP_HOLD) || (st_r == BRK_RUN_COAST);
	wire logic tick = waiting && (cnt_r == TICK_LAST);

	always_comb
	begin
		st_nxt = st_r;
		unique case (st_r)
			BRK_OFF:
				if (lnk.servo_on_req)
					st_nxt = BRK_ON_RUN;
			BRK_ON_RUN:
				if (!lnk.servo_on_req)
					st_nxt = lnk.below_speed ? BRK_STOP_HOLD : BRK_RUN_COAST;
			BRK_STOP_HOLD:
				if (lnk.servo_on_req)
					st_nxt = BRK_ON_RUN;
				else if (ticks_r >= lnk.wait_stop)
					st_nxt = BRK_OFF;
			BRK_RUN_COAST:
				if (lnk.servo_on_req)
					st_nxt = BRK_ON_RUN;
				else if (lnk.below_speed || ticks_r >= lnk.wait_run)
					st_nxt = BRK_OFF;
		endcase
	end

	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			st_r <= BRK_OFF;
			cnt_r <= '0;
			ticks_r <= '0;
			release_r <= LVL_OFF;
			energized_r <= LVL_OFF;
		end
		else
		begin
			st_r <= st_nxt;
			cnt_r <= (!waiting || tick || st_nxt != st_r) ? '0 : cnt_r + 1'b1;
			ticks_r <= (st_nxt != st_r) ? '0 : ticks_r + BRAKE_PARAM_W'(tick);
			// Brake stays released while motor still coasts so it is not worn down
			release_r <= (st_nxt == BRK_ON_RUN) || (st_nxt == BRK_RUN_COAST);
			energized_r <= (st_nxt == BRK_ON_RUN) || (st_nxt == BRK_STOP_HOLD);
		end
	end

	assign lnk.brake_release = release_r;
	assign lnk.servo_energized = energized_r;
endmodule
`default_nettype wire

// ---- logic/servo_control_io_routing.sv ----
// Sequence I/O function routing of the servo drive control connector
`timescale 1ns/1ps
`default_nettype none
//Function
// - Alarm output goes OFF whenever an alarm is active.
// - Position done A is ON in position mode while deviation magnitude is within range A.
// - Position done B is ON in position mode while deviation magnitude is within range B.
// - Speed match is ON in speed mode while speed error is within range.
// - Rotation detect is ON while speed magnitude exceeds its threshold.
// - Rotation detect is forced ON while no encoder is connected.
// - Current clamp output is ON while output current is limited.
// - Speed clamp output is ON in torque mode while speed is limited.
// - Brake interlock follows three timing settings relative to servo state.
// - Warning is ON on overload or regeneration overload warning.
// - General-purpose input level is reported for the network monitor field.
// - Decel and overtravel functions route to any of seven input terminals.
// - Latch triggers route only among the three latch-capable terminals.
// - A rising latch trigger captures the feedback counter value.
// - Status functions route to the three output pairs by allocation settings.
// - General-purpose outputs get functions only from allocation settings.
// - Routed decel input is the origin-search deceleration request.
// - Routed forward overtravel input is the forward drive-prohibit indication.
// - Routed reverse overtravel input is the reverse drive-prohibit indication.
// - Alarm output is OFF at power-up until initial processing completes.
// - An asserted overtravel input permits that direction; absence prohibits unless that input is unassigned.
module servo_control_io_routing
	import io_route_pkg::*;
#(
	parameter int POS_W = 32,
	parameter int SPD_W = 16,
	parameter int CNT_W = 32,
	parameter int BRAKE_TICK = BRAKE_TICK_CYCLES
)
(
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic seq_input_term_0,
	input wire logic seq_input_term_1,
	input wire logic seq_input_term_2,
	input wire logic seq_input_term_3,
	input wire logic seq_input_term_4,
	input wire logic seq_input_term_5,
	input wire logic seq_input_term_6,
	input wire logic [SEL_W-1:0] input_alloc_param_a,
	input wire logic [SEL_W-1:0] input_alloc_param_b,
	input wire logic [4*SEL_W-1:0] input_alloc_param_c,
	input wire logic [2*SEL_W-1:0] output_alloc_param_first,
	input wire logic [SEL_W-1:0] output_alloc_param_last,
	input wire logic [POS_W-1:0] done_range_a_param,
	input wire logic [POS_W-1:0] done_range_b_param,
	input wire logic [SPD_W-1:0] speed_match_range_param,
	input wire logic [SPD_W-1:0] rotation_threshold_param,
	input wire logic [BRAKE_PARAM_W-1:0] brake_timing_param_a,
	input wire logic [SPD_W-1:0] brake_timing_param_b,
	input wire logic [BRAKE_PARAM_W-1:0] brake_timing_param_c,
	input wire logic [1:0] control_mode,
	input wire logic signed [POS_W-1:0] position_deviation,
	input wire logic signed [SPD_W-1:0] motor_speed,
	input wire logic signed [SPD_W-1:0] speed_error,
	input wire logic encoder_present,
	input wire logic current_limited,
	input wire logic speed_limited,
	input wire logic overload_warn,
	input wire logic regen_overload_warn,
	input wire logic main_power_ok,
	input wire logic alarm_active,
	input wire logic init_done,
	input wire logic servo_on_req,
	input wire logic origin_search_active,
	input wire logic [CNT_W-1:0] feedback_count,
	input wire logic latch_clear_a,
	input wire logic latch_clear_b,
	input wire logic latch_clear_c,
	output logic alarm_out,
	output logic seq_output_pair_1,
	output logic seq_output_pair_2,
	output logic seq_output_pair_3,
	output logic servo_energized,
	output logic origin_decel_in,
	output logic origin_decel_req,
	output logic fwd_overtravel_in,
	output logic rev_overtravel_in,
	output logic fwd_drive_permit,
	output logic rev_drive_permit,
	output logic io_monitor_gp,
	output logic [CNT_W-1:0] latch_value_a,
	output logic [CNT_W-1:0] latch_value_b,
	output logic [CNT_W-1:0] latch_value_c,
	output logic latch_done_a,
	output logic latch_done_b,
	output logic latch_done_c
);
	// Codes above the last terminal leave an input function unassigned
	function automatic logic term_unused(input logic [SEL_W-1:0] sel);
		term_unused = (sel >= SEL_W'(N_IN_TERMS));
	endfunction

	// Any-terminal pick
	function automatic logic term_pick(input logic [SEL_W-1:0] sel, input logic [6:0] t);
		term_pick = !term_unused(sel) ? t[sel[2:0]] : 1'b0;
	endfunction

	// Latch pick; codes outside the latch-capable window mean unassigned
	function automatic logic latch_pick(input logic [SEL_W-1:0] sel, input logic [6:0] t);
		logic ok;
		ok = (sel >= LATCH_TERM_FIRST) && (sel <= LATCH_TERM_LAST);
		latch_pick = ok ? t[sel[2:0]] : 1'b0;
	endfunction

	// Output pair pick by function code; unknown codes drive OFF
	function automatic logic func_pick(input logic [SEL_W-1:0] code, input logic [9:0] fv);
		func_pick = (code <= SEL_W'(FUNC_WARN)) ? fv[code] : LVL_OFF;
	endfunction

	function automatic logic [POS_W-1:0] mag_pos(input logic signed [POS_W-1:0] v);
		mag_pos = v[POS_W-1] ? POS_W'(-v) : POS_W'(v);
	endfunction

	function automatic logic [SPD_W-1:0] mag_spd(input logic signed [SPD_W-1:0] v);
		mag_spd = v[SPD_W-1] ? SPD_W'(-v) : SPD_W'(v);
	endfunction

	brake_link_if brk ();

	brake_sequencer #(
		.TICK_CYCLES(BRAKE_TICK)
	) u_brake (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.lnk(brk.tmr)
	);

	wire logic [6:0] terms = {seq_input_term_6, seq_input_term_5, seq_input_term_4,
		seq_input_term_3, seq_input_term_2, seq_input_term_1, seq_input_term_0};

	wire logic decel_w = term_pick(input_alloc_param_c[DECEL_LSB +: SEL_W], terms);
	wire logic fwd_w = term_pick(input_alloc_param_a, terms);
	wire logic rev_w = term_pick(input_alloc_param_b, terms);
	wire logic latch_trigger_a =
		latch_pick(input_alloc_param_c[LATCH_A_LSB +: SEL_W], terms);
	wire logic latch_trigger_b =
		latch_pick(input_alloc_param_c[LATCH_B_LSB +: SEL_W], terms);
	wire logic latch_trigger_c =
		latch_pick(input_alloc_param_c[LATCH_C_LSB +: SEL_W], terms);
	wire logic [2:0] trig_now = {latch_trigger_c, latch_trigger_b, latch_trigger_a};

	wire logic in_pos = (control_mode == MODE_POSITION);
	wire logic in_spd = (control_mode == MODE_SPEED);
	wire logic in_trq = (control_mode == MODE_TORQUE);
	wire logic [POS_W-1:0] dev_mag = mag_pos(position_deviation);
	wire logic [SPD_W-1:0] spd_mag = mag_spd(motor_speed);
	wire logic [SPD_W-1:0] err_mag = mag_spd(speed_error);

	wire logic position_done_a = in_pos && (dev_mag <= done_range_a_param);
	wire logic position_done_b = in_pos && (dev_mag <= done_range_b_param);
	wire logic speed_match_out = in_spd && (err_mag <= speed_match_range_param);
	// Without feedback the speed compare is meaningless, so report rotating
	wire logic rotation_detect_out = !encoder_present
		|| (spd_mag > rotation_threshold_param);
	wire logic servo_ready_w = init_done && main_power_ok && !alarm_active;
	wire logic current_clamp_out = current_limited;
	wire logic speed_clamp_out = in_trq && speed_limited;
	wire logic brake_interlock_out = brk.brake_release;
	wire logic warn_w = overload_warn || regen_overload_warn;

	wire logic [9:0] func_vec = {warn_w, brake_interlock_out, speed_clamp_out,
		current_clamp_out, servo_ready_w, rotation_detect_out, speed_match_out,
		position_done_b, position_done_a, LVL_OFF};

	wire logic [SEL_W-1:0] pair1_code = output_alloc_param_first[PAIR1_LSB +: SEL_W];
	wire logic [SEL_W-1:0] pair2_code = output_alloc_param_first[PAIR2_LSB +: SEL_W];
	wire logic [SEL_W-1:0] pair3_code = output_alloc_param_last[PAIR3_LSB +: SEL_W];

	// Rising edge so a held trigger latches once, not every cycle
	logic [2:0] trig_prev_r;
	wire logic [2:0] trig_rise = trig_now & ~trig_prev_r;
	wire logic [2:0] clr = {latch_clear_c, latch_clear_b, latch_clear_a};
	logic [2:0] latch_done_r;

	assign brk.servo_on_req = servo_on_req && servo_ready_w;
	assign brk.below_speed = spd_mag < brake_timing_param_b;
	assign brk.wait_stop = brake_timing_param_a;
	assign brk.wait_run = brake_timing_param_c;
	assign servo_energized = brk.servo_energized;

	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			alarm_out <= LVL_OFF;
		end
		else
		begin
			alarm_out <= init_done && !alarm_active;
		end
	end

	// Pairs power up with no function and follow only the allocation codes
	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			seq_output_pair_1 <= LVL_OFF;
			seq_output_pair_2 <= LVL_OFF;
			seq_output_pair_3 <= LVL_OFF;
		end
		else
		begin
			seq_output_pair_1 <= func_pick(pair1_code, func_vec);
			seq_output_pair_2 <= func_pick(pair2_code, func_vec);
			seq_output_pair_3 <= func_pick(pair3_code, func_vec);
		end
	end

	// Decel level reaches the homing logic only during origin search
	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			origin_decel_in <= LVL_OFF;
			origin_decel_req <= LVL_OFF;
		end
		else
		begin
			origin_decel_in <= decel_w;
			origin_decel_req <= decel_w && origin_search_active;
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			fwd_overtravel_in <= LVL_OFF;
			rev_overtravel_in <= LVL_OFF;
			fwd_drive_permit <= LVL_OFF;
			rev_drive_permit <= LVL_OFF;
		end
		else
		begin
			fwd_overtravel_in <= fwd_w;
			rev_overtravel_in <= rev_w;
			// Unassigned overtravel reads inactive, which leaves prohibition disabled
			fwd_drive_permit <= fwd_w || term_unused(input_alloc_param_a);
			rev_drive_permit <= rev_w || term_unused(input_alloc_param_b);
		end
	end

	// Raw terminal level; the host reads it through the monitor field
	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			io_monitor_gp <= LVL_OFF;
		end
		else
		begin
			io_monitor_gp <= seq_input_term_0;
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			trig_prev_r <= '0;
			latch_done_r <= '0;
		end
		else
		begin
			trig_prev_r <= trig_now;
			// A new capture beats a clear in the same cycle
			latch_done_r <= trig_rise | (latch_done_r & ~clr);
		end
	end

	// Values hold until the next rising trigger; a clear drops only the flag
	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			latch_value_a <= '0;
			latch_value_b <= '0;
			latch_value_c <= '0;
		end
		else
		begin
			if (trig_rise[0])
				latch_value_a <= feedback_count;
			if (trig_rise[1])
				latch_value_b <= feedback_count;
			if (trig_rise[2])
				latch_value_c <= feedback_count;
		end
	end

	assign latch_done_a = latch_done_r[0];
	assign latch_done_b = latch_done_r[1];
	assign latch_done_c = latch_done_r[2];
endmodule
`default_nettype wire

// ---- test/io_route_asserts.sv ----
// Concurrent checks on the I/O routing top ports
`timescale 1ns/1ps
`default_nettype none
module io_route_asserts
	import io_route_pkg::*;
#(
	parameter int CNT_W = 32
)
(
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic seq_input_term_0,
	input wire logic seq_input_term_1,
	input wire logic seq_input_term_2,
	input wire logic seq_input_term_3,
	input wire logic seq_input_term_4,
	input wire logic seq_input_term_5,
	input wire logic seq_input_term_6,
	input wire logic [SEL_W-1:0] input_alloc_param_a,
	input wire logic [SEL_W-1:0] input_alloc_param_b,
	input wire logic [4*SEL_W-1:0] input_alloc_param_c,
	input wire logic [2*SEL_W-1:0] output_alloc_param_first,
	input wire logic [CNT_W-1:0] feedback_count,
	input wire logic overload_warn,
	input wire logic regen_overload_warn,
	input wire logic alarm_active,
	input wire logic init_done,
	input wire logic alarm_out,
	input wire logic seq_output_pair_1,
	input wire logic fwd_overtravel_in,
	input wire logic rev_overtravel_in,
	input wire logic fwd_drive_permit,
	input wire logic rev_drive_permit,
	input wire logic io_monitor_gp,
	input wire logic [CNT_W-1:0] latch_value_a,
	input wire logic latch_done_a
);
	wire logic [6:0] term = {seq_input_term_6, seq_input_term_5, seq_input_term_4,
		seq_input_term_3, seq_input_term_2, seq_input_term_1, seq_input_term_0};
	wire logic [3:0] lat_sel = input_alloc_param_c[7:4];
	wire logic lat_ok = lat_sel >= LATCH_TERM_FIRST && lat_sel <= LATCH_TERM_LAST;
	wire logic lat_trig = lat_ok && term[lat_sel[2:0]];

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (sys_rst);

	alarm_off_a: assert property (alarm_active |=> !alarm_out)
		else $error("alarm output on during alarm");
	alarm_init_a: assert property (!init_done |=> !alarm_out)
		else $error("alarm output on before init");
	gp_monitor_a: assert property (1'b1 |=> io_monitor_gp == $past(seq_input_term_0))
		else $error("monitor bit differs from terminal");
	fwd_route_a: assert property (input_alloc_param_a < 4'h7
		|=> fwd_overtravel_in == $past(term[input_alloc_param_a[2:0]]))
		else $error("forward overtravel misrouted");
	fwd_permit_a: assert property (input_alloc_param_a < 4'h7
		|=> fwd_drive_permit == fwd_overtravel_in)
		else $error("forward permit wrong");
	rev_unassigned_a: assert property (input_alloc_param_b >= 4'h7
		|=> rev_drive_permit && !rev_overtravel_in)
		else $error("unassigned reverse input not inactive");
	latch_capture_a: assert property (lat_trig && !$past(lat_trig)
		|=> latch_done_a && latch_value_a == $past(feedback_count))
		else $error("latch missed a rising trigger");
	pair_none_a: assert property (output_alloc_param_first[3:0] == 4'h0
		|=> !seq_output_pair_1)
		else $error("unassigned output pair on");
	pair_warn_a: assert property (output_alloc_param_first[3:0] == FUNC_WARN
		|=> seq_output_pair_1 == $past(overload_warn || regen_overload_warn))
		else $error("warning output wrong");

	latch_rise_c: cover property (lat_trig && !$past(lat_trig));
	rev_block_c: cover property (!rev_drive_permit);
	alarm_up_c: cover property ($rose(alarm_out));
endmodule

bind servo_control_io_routing io_route_asserts #(.CNT_W(CNT_W)) u_chk (
	.ref_clk, .sys_rst, .seq_input_term_0, .seq_input_term_1, .seq_input_term_2,
	.seq_input_term_3, .seq_input_term_4, .seq_input_term_5, .seq_input_term_6,
	.input_alloc_param_a, .input_alloc_param_b, .input_alloc_param_c,
	.output_alloc_param_first, .feedback_count, .overload_warn, .regen_overload_warn,
	.alarm_active, .init_done, .alarm_out, .seq_output_pair_1, .fwd_overtravel_in,
	.rev_overtravel_in, .fwd_drive_permit, .rev_drive_permit, .io_monitor_gp,
	.latch_value_a, .latch_done_a);
`default_nettype wire

// ---- test/seq_wiring_model.sv ----
// Machine-side contact wiring feeding the sequence input terminals
`timescale 1ns/1ps
`default_nettype none
module seq_wiring_model
(
	input wire logic [6:0] contact_set,
	output logic [6:0] seq_term
);
	// Dry contacts: an open contact carries no current and reads OFF
	assign seq_term = contact_set;
endmodule
`default_nettype wire

// ---- test/servo_control_io_routing_tb.sv ----
// Self-checking bench for the control connector I/O routing
`timescale 1ns/1ps
`default_nettype none
`define CHECK(what, exp, got) begin n_tests++; if ((got) !== (exp)) begin failures++; \
	$display("wrong value %s expected %h seen %h", what, exp, got); end end
module servo_control_io_routing_tb;
	import io_route_pkg::*;
	localparam int BT = 4;
	int failures = 0, n_tests = 0;
	logic ref_clk = 1'b0, sys_rst = 1'b1;
	logic [6:0] contacts = '0;
	wire logic [6:0] term;
	logic [3:0] alloc_a = 4'hf, alloc_b = 4'hf, out_last = 4'h0;
	logic [15:0] alloc_c = 16'h0000;
	logic [7:0] out_first = 8'h00, brk_a = 8'h02, brk_c = 8'h03;
	logic [31:0] range_a = 32'h0000_000a, range_b = 32'h0000_0003, count = '0;
	logic [15:0] match_rng = 16'h0004, rot_thr = 16'h0064, brk_speed = 16'h000a;
	logic [1:0] mode = 2'h0;
	logic signed [31:0] dev = '0;
	logic signed [15:0] spd = '0, serr = '0;
	logic enc = 1'b1, cl = 1'b0, sl = 1'b0, ow = 1'b0, rw = 1'b0, pwr = 1'b1;
	logic fault = 1'b0, init = 1'b0, son = 1'b0, osa = 1'b0;
	logic [2:0] lclr = '0;
	wire logic alarm_seen, energized, decel_o, decel_rq, fwd_in, rev_in, fwd_ok, rev_ok, gp;
	wire logic [2:0] pair, ldone;
	wire logic [31:0] lv [3];

	seq_wiring_model u_wiring (.contact_set(contacts), .seq_term(term));
	servo_control_io_routing #(.BRAKE_TICK(BT)) u_dut (
		.ref_clk(ref_clk), .sys_rst(sys_rst), .seq_input_term_0(term[0]),
		.seq_input_term_1(term[1]), .seq_input_term_2(term[2]), .seq_input_term_3(term[3]),
		.seq_input_term_4(term[4]), .seq_input_term_5(term[5]), .seq_input_term_6(term[6]),
		.input_alloc_param_a(alloc_a), .input_alloc_param_b(alloc_b),
		.input_alloc_param_c(alloc_c), .output_alloc_param_first(out_first),
		.output_alloc_param_last(out_last), .done_range_a_param(range_a),
		.done_range_b_param(range_b), .speed_match_range_param(match_rng),
		.rotation_threshold_param(rot_thr), .brake_timing_param_a(brk_a),
		.brake_timing_param_b(brk_speed), .brake_timing_param_c(brk_c),
		.control_mode(mode), .position_deviation(dev), .motor_speed(spd), .speed_error(serr),
		.encoder_present(enc), .current_limited(cl), .speed_limited(sl), .overload_warn(ow),
		.regen_overload_warn(rw), .main_power_ok(pwr), .alarm_active(fault), .init_done(init),
		.servo_on_req(son), .origin_search_active(osa), .feedback_count(count),
		.latch_clear_a(lclr[0]), .latch_clear_b(lclr[1]), .latch_clear_c(lclr[2]),
		.alarm_out(alarm_seen), .seq_output_pair_1(pair[0]), .seq_output_pair_2(pair[1]),
		.seq_output_pair_3(pair[2]), .servo_energized(energized), .origin_decel_in(decel_o),
		.origin_decel_req(decel_rq), .fwd_overtravel_in(fwd_in), .rev_overtravel_in(rev_in),
		.fwd_drive_permit(fwd_ok), .rev_drive_permit(rev_ok), .io_monitor_gp(gp),
		.latch_value_a(lv[0]), .latch_value_b(lv[1]), .latch_value_c(lv[2]),
		.latch_done_a(ldone[0]), .latch_done_b(ldone[1]), .latch_done_c(ldone[2]));

	always #25 ref_clk = ~ref_clk;

	task automatic give_verdict();
		if (failures == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic tick(int n = 1);
		repeat (n) @(negedge ref_clk);
	endtask

	function automatic logic exp_func(logic [3:0] c);
		longint d, e, s;
		d = dev < 0 ? -longint'(dev) : longint'(dev);
		e = serr < 0 ? -longint'(serr) : longint'(serr);
		s = spd < 0 ? -longint'(spd) : longint'(spd);
		case (c)
			4'h1: return mode == MODE_POSITION && d <= range_a;
			4'h2: return mode == MODE_POSITION && d <= range_b;
			4'h3: return mode == MODE_SPEED && e <= match_rng;
			4'h4: return !enc || s > rot_thr;
			4'h5: return init && pwr && !fault;
			4'h6: return cl;
			4'h7: return mode == MODE_TORQUE && sl;
			4'h9: return ow || rw;
			default: return 1'b0;
		endcase
	endfunction

	task automatic t_alarm();
		tick();
		`CHECK("alarm", 1'b0, alarm_seen)
		`CHECK("pairs", 3'h0, pair)
		init = 1'b1;
		tick();
		`CHECK("alarm", 1'b1, alarm_seen)
		fault = 1'b1;
		tick();
		`CHECK("alarm", 1'b0, alarm_seen)
		fault = 1'b0;
	endtask

	task automatic t_route();
		for (int k = 0; k < 7; k++)
		begin
			contacts = 7'(1 << k);
			alloc_a = 4'(k);
			alloc_b = 4'((k + 1) % 7);
			alloc_c[3:0] = 4'(k);
			osa = k[0];
			tick();
			`CHECK("fwd routed", 1'b1, fwd_in)
			`CHECK("fwd permit", 1'b1, fwd_ok)
			`CHECK("rev routed", 1'b0, rev_in)
			`CHECK("rev permit", 1'b0, rev_ok)
			`CHECK("decel", {1'b1, osa}, {decel_o, decel_rq})
			`CHECK("gp monitor", k == 0, gp)
		end
		contacts = 7'h7f;
		alloc_a = 4'h7;
		alloc_b = 4'hf;
		alloc_c[3:0] = 4'h9;
		tick();
		`CHECK("unassigned in", 3'h0, {fwd_in, rev_in, decel_o})
		`CHECK("unassigned permit", 2'h3, {fwd_ok, rev_ok})
	endtask

	task automatic t_latch();
		logic [3:0] t;
		for (int ch = 0; ch < 3; ch++)
		begin
			t = 4'(4 + (ch + 1) % 3);
			alloc_c[4 * ch + 4 +: 4] = t;
			contacts = '0;
			tick();
			contacts[t] = 1'b1;
			count = 32'h00c0_0000 + 32'(ch);
			tick();
			`CHECK("latch value", count, lv[ch])
			`CHECK("latch done", 1'b1, ldone[ch])
			count = count + 32'h0000_0001;
			tick();
			`CHECK("latch held", count - 32'h0000_0001, lv[ch])
			lclr[ch] = 1'b1;
			tick();
			lclr[ch] = 1'b0;
			`CHECK("latch clear", 1'b0, ldone[ch])
			alloc_c[4 * ch + 4 +: 4] = 4'h3;
			contacts = '0;
			tick();
			contacts[3] = 1'b1;
			tick();
			`CHECK("latch off terminal", 1'b0, ldone[ch])
		end
	endtask

	task automatic cond(logic [1:0] m, int d, int e, int s, logic [5:0] b);
		mode = m;
		dev = 32'(d);
		serr = 16'(e);
		spd = 16'(s);
		{enc, cl, sl, ow, rw, pwr} = b;
		for (int c = 0; c < 16; c++)
		begin
			if (c == 8)
				continue;
			out_first = {4'(c), 4'(c)};
			out_last = 4'(c);
			tick();
			`CHECK("pairs", {3{exp_func(4'(c))}}, pair)
		end
	endtask

	task automatic t_outs();
		// Boundaries: deviation equal to range, speed equal to threshold
		cond(MODE_POSITION, -10, 0, 100, 6'b111011);
		cond(MODE_SPEED, 3, -4, -101, 6'b101101);
		cond(MODE_TORQUE, 0, 5, 0, 6'b001000);
	endtask

	task automatic t_brake();
		int n;
		{enc, pwr} = 2'b11;
		out_last = FUNC_BRAKE;
		spd = '0;
		son = 1'b1;
		tick(3);
		`CHECK("on", 2'h3, {energized, pair[2]})
		son = 1'b0;
		tick(2);
		`CHECK("stop hold", 2'h2, {energized, pair[2]})
		n = 2;
		while (energized === 1'b1 && n < 40)
		begin
			tick();
			n++;
		end
		`CHECK("hold time", 1'b1, n >= 2 * BT && n <= 2 * BT + 3)
		if (n >= 40)
			give_verdict();
		son = 1'b1;
		tick(3);
		spd = 16'sd500;
		son = 1'b0;
		tick(2);
		`CHECK("coast", 2'h1, {energized, pair[2]})
		tick(8);
		`CHECK("coast wait", 1'b1, pair[2])
		tick(5);
		`CHECK("coast end", 1'b0, pair[2])
		spd = '0;
	endtask

	initial
	begin
		repeat (8) @(negedge ref_clk);
		sys_rst = 1'b0;
		t_alarm();
		t_route();
		t_latch();
		t_outs();
		t_brake();
		give_verdict();
	end
endmodule
`default_nettype wire
